// >>> design/prot_stage_defs.vh
// constants for the programmable protection stage
// Functional notes
// - selectable evaluation interval, shortest for fast operate
// - four modes: over, under, signed, absolute difference
// - secondary signal used only in difference modes
// - absolute mode trips when magnitude exceeds limit
// - signed mode trips on positive difference over limit
// - start limit is the threshold, signal units
// - operate after definite-time delay elapses
// - dead band delays release past limit
// - under mode compares only at or above floor
// - supervised signal selectable from measured quantities
`ifndef PROT_STAGE_DEFS_VH
`define PROT_STAGE_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define REG_CONTROL 8'h00
`define REG_START_LIMIT 8'h04
`define REG_DEAD_BAND 8'h08
`define REG_FLOOR 8'h0C
`define REG_DELAY 8'h10
`define REG_STATUS 8'h14
`define REG_IRQ_STATUS 8'h18
`define REG_IRQ_ENABLE 8'h1C
`define REG_IRQ_CLEAR 8'h20
`define REG_VALUE 8'h24
// ****************************************
// control fields
// ****************************************
`define CTL_MODE_LSB 0
`define CTL_PRIO_LSB 2
`define CTL_SEL_A_LSB 4
`define CTL_SEL_B_LSB 9
`define CTL_ENABLE_BIT 14
// ****************************************
// modes, priorities
// ****************************************
`define MODE_OVER 2'd0
`define MODE_UNDER 2'd1
`define MODE_DIFF 2'd2
`define MODE_ABS_DIFF 2'd3
`define PRIO_10MS 2'd0
`define PRIO_20MS 2'd1
`define PRIO_100MS 2'd2
// ****************************************
// reset values and timing
// ****************************************
`define CONTROL_RESET 32'h0000_0000
`define DELAY_RESET 16'h0000
`define INTERVAL_10_MS 10
`define INTERVAL_20_MS 20
`define INTERVAL_100_MS 100
`define CLOCK_KHZ 200000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> design/prot_stage.v
// programmable protection stage with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "prot_stage_defs.vh"
module prot_stage #(
   parameter NUM_SIGNALS = 32,
   parameter [31:0] CYCLES_PER_MS = `CLOCK_KHZ / 1000
) (
   input wire aclk,
   input wire aresetn,
   input wire [NUM_SIGNALS*32-1:0] signal_values,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg stage_start,
   output reg stage_operate,
   output reg irq
);
   // ****************************************
   // registers
   // ****************************************
   reg [31:0] control;
   reg signed [31:0] start_limit;
   reg signed [31:0] dead_band;
   reg signed [31:0] floor_limit;
   reg [15:0] delay_intervals;
   reg [1:0] irq_status;
   reg [1:0] irq_enable;
   reg signed [31:0] last_value;
   reg [7:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;
   wire [1:0] mode = control[`CTL_MODE_LSB +: 2];
   wire [1:0] prio = control[`CTL_PRIO_LSB +: 2];
   wire [4:0] sel_a = control[`CTL_SEL_A_LSB +: 5];
   wire [4:0] sel_b = control[`CTL_SEL_B_LSB +: 5];
   wire stage_enable = control[`CTL_ENABLE_BIT];

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) merge[k*8 +: 8] = data[k*8 +: 8];
         end
      end
   endfunction

   function signed [31:0] pick;
      input [NUM_SIGNALS*32-1:0] vals;
      input [4:0] idx;
      begin
         pick = vals[idx*32 +: 32];
      end
   endfunction

   // ****************************************
   // write channel
   // ****************************************
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire [1:0] stage_events;
   wire [31:0] delay_merged = merge({16'h0000, delay_intervals}, w_data, w_strb);
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         control <= `CONTROL_RESET;
         start_limit <= 32'h0000_0000;
         dead_band <= 32'h0000_0000;
         floor_limit <= 32'h0000_0000;
         delay_intervals <= `DELAY_RESET;
         irq_enable <= 2'b00;
         irq_status <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // hardware set wins over software clear
         irq_status <= irq_status | stage_events;
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (aw_addr)
               `REG_CONTROL: control <= merge(control, w_data, w_strb);
               `REG_START_LIMIT: start_limit <= merge(start_limit, w_data, w_strb);
               `REG_DEAD_BAND: dead_band <= merge(dead_band, w_data, w_strb);
               `REG_FLOOR: floor_limit <= merge(floor_limit, w_data, w_strb);
               `REG_DELAY: delay_intervals <= delay_merged[15:0];
               `REG_IRQ_ENABLE: irq_enable <= w_data[1:0] & {2{w_strb[0]}};
               `REG_IRQ_CLEAR: irq_status <= (irq_status & ~(w_data[1:0] & {2{w_strb[0]}}))
                  | stage_events;
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ****************************************
   // read channel
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (s_axi_araddr)
            `REG_CONTROL: s_axi_rdata <= control;
            `REG_START_LIMIT: s_axi_rdata <= start_limit;
            `REG_DEAD_BAND: s_axi_rdata <= dead_band;
            `REG_FLOOR: s_axi_rdata <= floor_limit;
            `REG_DELAY: s_axi_rdata <= {16'h0000, delay_intervals};
            `REG_STATUS: s_axi_rdata <= {30'h0000_0000, stage_operate, stage_start};
            `REG_IRQ_STATUS: s_axi_rdata <= {30'h0000_0000, irq_status};
            `REG_IRQ_ENABLE: s_axi_rdata <= {30'h0000_0000, irq_enable};
            `REG_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
            `REG_VALUE: s_axi_rdata <= last_value;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ****************************************
   // evaluation interval tick
   // ****************************************
   reg [31:0] tick_count;
   reg [31:0] interval_ms;
   always @* begin
      case (prio)
         `PRIO_10MS: interval_ms = `INTERVAL_10_MS;
         `PRIO_20MS: interval_ms = `INTERVAL_20_MS;
         default: interval_ms = `INTERVAL_100_MS;
      endcase
   end
   wire [31:0] interval_cycles = interval_ms * CYCLES_PER_MS;
   wire tick = (tick_count >= interval_cycles - 32'd1);
   always @(posedge aclk) begin
      if (!aresetn || tick || !stage_enable) tick_count <= 32'h0000_0000;
      else tick_count <= tick_count + 32'd1;
   end

   // ****************************************
   // comparison
   // ****************************************
   wire signed [31:0] value_a = pick(signal_values, sel_a);
   wire signed [31:0] value_b = pick(signal_values, sel_b);
   wire is_diff = mode[1];
   // secondary used only in difference modes
   wire signed [32:0] diff = {value_a[31], value_a} - (is_diff ? {value_b[31], value_b}
      : 33'sd0);
   wire signed [32:0] magnitude = diff[32] ? -diff : diff;
   wire signed [32:0] limit = {start_limit[31], start_limit};
   wire signed [32:0] band = {dead_band[31], dead_band};
   reg next_start;
   always @* begin
      next_start = stage_start;
      case (mode)
         `MODE_OVER: next_start = stage_start ? (diff > limit - band) : (diff > limit);
         `MODE_UNDER: begin
            if (value_a < floor_limit) next_start = 1'b0;
            else next_start = stage_start ? (diff < limit + band) : (diff < limit);
         end
         `MODE_DIFF: next_start = !diff[32] && (stage_start ? (diff > limit - band)
            : (diff > limit));
         default: next_start = stage_start ? (magnitude > limit - band)
            : (magnitude > limit);
      endcase
   end

   // ****************************************
   // definite-time delay
   // ****************************************
   reg [15:0] delay_count;
   assign stage_events = {stage_enable && tick && next_start && !stage_operate
      && delay_count >= delay_intervals, stage_enable && tick && next_start && !stage_start};
   always @(posedge aclk) begin
      if (!aresetn || !stage_enable) begin
         stage_start <= 1'b0;
         stage_operate <= 1'b0;
         delay_count <= 16'h0000;
         last_value <= 32'h0000_0000;
      end else if (tick) begin
         stage_start <= next_start;
         last_value <= diff[31:0];
         if (!next_start) begin
            delay_count <= 16'h0000;
            stage_operate <= 1'b0;
         end else if (delay_count >= delay_intervals) begin
            stage_operate <= 1'b1;
         end else begin
            delay_count <= delay_count + 16'h0001;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) irq <= 1'b0;
      else irq <= |(irq_status & irq_enable);
   end
endmodule // prot_stage
`default_nettype wire

// >>> sim/prot_stage_assertions.sv
// port assertions for the protection stage
`timescale 1ns/1ps
`default_nettype none
module prot_stage_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stage_start,
   input wire logic stage_operate,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_oper_needs_start: assert property (stage_operate |-> stage_start)
      else $error("operate without start");
   chk_oper_after_start: assert property ($rose(stage_operate) |-> $past(stage_start) || $rose(stage_start))
      else $error("operate rose without prior start");
   chk_drop_clears_oper: assert property ($fell(stage_start) |-> !stage_operate)
      else $error("operate kept after condition loss");
   chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address open while response pending");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response dropped early");
   chk_reset_quiet: assert property (disable iff (1'b0)
      !aresetn |=> !stage_start && !stage_operate && !irq && !s_axi_bvalid)
      else $error("outputs active after reset");
endmodule // prot_stage_chk
`default_nettype wire

// >>> sim/meas_chain.sv
// measurement chain model feeding supervised values
`timescale 1ns/1ps
`default_nettype none
module meas_chain #(parameter int N = 4) (
   input wire logic aclk,
   input wire logic [31:0] val_a,
   input wire logic [31:0] val_b,
   output logic [N*32-1:0] signal_values
);
   // channels 1 and 2 are steered, the rest carry fixed values
   always @(posedge aclk) begin
      for (int i = 0; i < N; i++) signal_values[i*32+:32] <= 32'(i * 1000);
      signal_values[63:32] <= val_a;
      signal_values[95:64] <= val_b;
   end
endmodule // meas_chain
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the protection stage
`timescale 1ns/1ps
`default_nettype none
`include "prot_stage_defs.vh"
module tb_top;
   logic aclk = 0;
   logic aresetn = 0;
   logic [31:0] val_a = 0;
   logic [31:0] val_b = 0;
   logic [7:0] awaddr = 0;
   logic bready = 0;
   logic rready = 0;
   logic [7:0] araddr = 0;
   logic [31:0] wdata = 0;
   logic awvalid = 0;
   logic wvalid = 0;
   logic arvalid = 0;
   wire [127:0] sigs;
   wire awready, wready, bvalid, arready, rvalid, start, operate, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int error_cnt = 0;
   int n_tests = 0;
   meas_chain #(.N(4)) u_meas (.aclk(aclk), .val_a(val_a), .val_b(val_b), .signal_values(sigs));
   prot_stage #(.NUM_SIGNALS(4), .CYCLES_PER_MS(1)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .signal_values(sigs), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .stage_start(start), .stage_operate(operate), .irq(irq));
   // ****************************************
   // bus and compare helpers
   // ****************************************
   initial begin
      forever #2.5 aclk = ~aclk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid && n < 50);
      if (n >= 50) error_cnt++;
      bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n = 0;
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 0;
      end while (!rvalid && n < 50);
      if (n >= 50) error_cnt++;
      check(rdata, e);
      check(rresp, er);
      rready <= 0;
      @(posedge aclk);
   endtask
   function automatic logic [31:0] ctl(input logic [1:0] m);
      return 32'h0000_4000 | m | (32'h1 << 4) | (32'h2 << 9);
   endfunction
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_over;
      rchk(`REG_CONTROL, 32'h0000_0000, `RESP_OKAY);
      rchk(8'h30, 32'h0000_0000, `RESP_SLVERR);
      val_a <= 32'd150;
      wr(`REG_START_LIMIT, 32'd100);
      wr(`REG_DEAD_BAND, 32'd10);
      wr(`REG_DELAY, 32'd2);
      wr(`REG_CONTROL, ctl(`MODE_OVER));
      wt(12);
      check(start, 1);
      check(operate, 0);
      wt(50);
      check(operate, 1);
      rchk(`REG_VALUE, 32'd150, `RESP_OKAY);
      val_a <= 32'd95;
      wt(25);
      check(start, 1);
      val_a <= 32'd80;
      wt(15);
      check(start, 0);
      $display("test over done");
   endtask
   task automatic t_restart;
      wr(`REG_DELAY, 32'd5);
      val_a <= 32'd150;
      wt(30);
      val_a <= 32'd50;
      wt(15);
      val_a <= 32'd150;
      wt(30);
      check(operate, 0);
      wt(50);
      check(operate, 1);
      $display("test restart done");
   endtask
   task automatic t_under;
      val_a <= 32'd10;
      wr(`REG_DELAY, 32'd0);
      wr(`REG_FLOOR, 32'd20);
      wr(`REG_CONTROL, ctl(`MODE_UNDER));
      wt(15);
      check(start, 0);
      val_a <= 32'd50;
      wt(15);
      check(start, 1);
      $display("test under done");
   endtask
   task automatic t_diff;
      val_b <= 32'd120;
      wr(`REG_CONTROL, ctl(`MODE_OVER));
      wt(15);
      check(start, 0);
      wr(`REG_START_LIMIT, 32'd30);
      wr(`REG_CONTROL, ctl(`MODE_DIFF));
      wt(15);
      check(start, 0);
      wr(`REG_CONTROL, ctl(`MODE_ABS_DIFF));
      wt(15);
      check(start, 1);
      rchk(`REG_VALUE, 32'hFFFF_FFBA, `RESP_OKAY);
      $display("test diff done");
   endtask
   task automatic t_irq;
      wr(`REG_IRQ_ENABLE, 32'h0000_0001);
      wt(3);
      check(irq, 1);
      rchk(`REG_IRQ_STATUS, 32'h0000_0003, `RESP_OKAY);
      rchk(`REG_IRQ_CLEAR, 32'h0000_0000, `RESP_OKAY);
      wr(`REG_IRQ_CLEAR, 32'h0000_0003);
      wt(3);
      check(irq, 0);
      rchk(`REG_IRQ_STATUS, 32'h0000_0000, `RESP_OKAY);
      wr(`REG_IRQ_ENABLE, 32'h0000_0003);
      wr(`REG_IRQ_ENABLE, 32'h0000_0000);
      wt(3);
      check(irq, 0);
      $display("test irq done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      error_cnt++;
      wrap_up;
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_over;
      t_restart;
      t_under;
      t_diff;
      t_irq;
      wrap_up;
   end
endmodule // tb_top
bind prot_stage prot_stage_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .stage_start, .stage_operate, .irq);
`default_nettype wire
